// [common/ppp_pkg.sv]
// Package for the parallel flash page programmer: pin codes, geometry, timing.
// Assumes a 100 MHz core clock; all pins arrive asynchronously.
package ppp_pkg;

    // Core clock period and strobe timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int MIN_PULSE_NS    = 250;
    localparam int MIN_PULSE_CYC   = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Page write duration, a plain default
    localparam int PROG_TIME_NS    = 40000;
    localparam int PROG_TIME_CYC   = PROG_TIME_NS / CLK_PERIOD_NS;

    // Action select codes {hi, lo}
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD  = 2'h2;

    // Commands
    localparam logic [7:0] CMD_NOP        = 8'h00;
    localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;

    // Flash geometry: 64-word pages, 128 pages
    localparam int WORD_BITS  = 6;
    localparam int PAGE_BITS  = 7;
    localparam int PAGE_WORDS = 64;

    // Reset values
    localparam logic [7:0]  BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] CNT_RST  = 16'h0000;

endpackage : ppp_pkg

// [hw/ppp_page_buf.sv]
// Page buffer memory: one write port, registered read port.
// Assumes write and read addresses come from logic on the same clock.
`timescale 1ns/100ps
module ppp_page_buf
    import ppp_pkg::*;
(
    // Clock
    input  wire logic                 mclk_i,
    // Write port
    input  wire logic                 wr_en_i,
    input  wire logic [WORD_BITS-1:0] wr_addr_i,
    input  wire logic [15:0]          wr_data_i,
    // Read port
    input  wire logic [WORD_BITS-1:0] rd_addr_i,
    output logic      [15:0]          rd_data_o
);

    logic [15:0] mem [PAGE_WORDS];

    // Storage and registered read
    always_ff @(posedge mclk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule : ppp_page_buf

// [hw/ppp_programmer.sv]
// Parallel programming front end: loads address, data and command bytes,
// latches words into a page buffer and runs a timed page write.
// Assumes all pin inputs are asynchronous and strobes last at least 250 ns.
`timescale 1ns/100ps
// Overview of operation
// R01: Programmer keeps every strobe pulse at least 250 ns wide.
// R02: Rising load strobe performs load action chosen by action select.
// R03: Write or output-enable strobe runs the last loaded command. Here only the write strobe does; output enable runs nothing.
// R04: Action 00, byte select low captures address low byte.
// R05: Action 01, byte select low captures data low byte.
// R06: Action 01, byte select high captures data high byte.
// R07: Page latch pulse with byte select high stores word in buffer.
// R08: Programmer repeats address, data, latch until page buffer full.
// R09: Low address bits pick word, upper bits including low byte top pick page.
// R10: Action 00, byte select high captures address high byte.
// R11: Write strobe low pulse starts page write; ready/busy goes low.
// R12: Programmer waits for ready/busy high before next step.
// R13: Programmer repeats page load and write for all pages.
// R14: Action 10 load of no-operation resets internal write signals.
// R15: Ready/busy stays high whenever no page write runs.
module ppp_programmer
    import ppp_pkg::*;
#(
    parameter int PROG_CYC = PROG_TIME_CYC
)
(
    // Clock and reset
    input  wire logic                 mclk_i,
    input  wire logic                 rst_b_i,
    // Programming pins
    input  wire logic                 load_strobe_pin_i,
    input  wire logic                 action_select_hi_i,
    input  wire logic                 action_select_lo_i,
    input  wire logic                 byte_select_i,
    input  wire logic                 page_latch_strobe_i,
    input  wire logic                 wr_b_i,
    input  wire logic                 oe_b_i,
    input  wire logic [7:0]           data_i,
    // Status and flash array side
    output logic                      ready_busy_out_o,
    output logic                      flash_we_o,
    output logic [PAGE_BITS-1:0]      flash_page_o,
    output logic [WORD_BITS-1:0]      flash_word_o,
    output logic [15:0]               flash_data_o,
    output logic [7:0]                command_o
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PROG = 3'b010,
        ST_DONE = 3'b100
    } ppp_state_e;

    typedef struct packed {
        ppp_state_e           st;
        logic [7:0]           addr_lo;
        logic [7:0]           addr_hi;
        logic [7:0]           data_lo;
        logic [7:0]           data_hi;
        logic [7:0]           cmd;
        logic [15:0]          cnt;
        logic [WORD_BITS-1:0] word;
        logic [PAGE_BITS-1:0] page;
        logic                 rdy;
        logic                 we;
        logic [15:0]          wdata;
        logic                 arm;
        logic [WORD_BITS-1:0] fword;
    } ppp_state_s;

    ppp_state_s st_r;
    ppp_state_s st_nxt;

    // Reset release synchroniser
    logic rst_m_r;
    logic rst_s_r;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_r <= rst_m_r;
        end
    end

    // Two-stage pin synchronisers, then one history stage for edges
    logic [12:0] pin_raw;
    logic [12:0] pin_m_r;
    logic [12:0] pin_s_r;
    logic [12:0] pin_d_r;
    assign pin_raw = {data_i, oe_b_i, wr_b_i, page_latch_strobe_i, load_strobe_pin_i, byte_select_i};
    always_ff @(posedge mclk_i or negedge rst_s_r) begin
        if (!rst_s_r) begin
            pin_m_r <= 13'h0018;
            pin_s_r <= 13'h0018;
            pin_d_r <= 13'h0018;
        end else begin
            pin_m_r <= pin_raw;
            pin_s_r <= pin_m_r;
            pin_d_r <= pin_s_r;
        end
    end

    logic [1:0] act_m_r;
    logic [1:0] act_s_r;
    always_ff @(posedge mclk_i or negedge rst_s_r) begin
        if (!rst_s_r) begin
            act_m_r <= 2'h0;
            act_s_r <= 2'h0;
        end else begin
            act_m_r <= {action_select_hi_i, action_select_lo_i};
            act_s_r <= act_m_r;
        end
    end

    // Decoded pin views
    logic       bs;
    logic [7:0] dbus;
    logic       load_rise;
    logic       latch_rise;
    logic       wr_fall;
    logic       oe_fall;
    assign bs         = pin_s_r[0];
    assign dbus       = pin_s_r[12:5];
    assign load_rise  = pin_s_r[1] & ~pin_d_r[1];
    assign latch_rise = pin_s_r[2] & ~pin_d_r[2];
    assign wr_fall    = ~pin_s_r[3] & pin_d_r[3];
    assign oe_fall    = ~pin_s_r[4] & pin_d_r[4];

    // Buffer read for the program walk
    logic [15:0] buf_rd;
    ppp_page_buf u_buf (
        .mclk_i    (mclk_i),
        .wr_en_i   (st_r.arm),
        .wr_addr_i (st_r.addr_lo[WORD_BITS-1:0]),
        .wr_data_i ({st_r.data_hi, st_r.data_lo}),
        .rd_addr_i (st_r.word),
        .rd_data_o (buf_rd)
    );

    // Next-state logic
    always_comb begin
        st_nxt     = st_r;
        st_nxt.we  = 1'b0;
        st_nxt.arm = 1'b0;
        if (load_rise && st_r.st == ST_IDLE) begin
            // R02: load by action select
            unique case (act_s_r)
                // R04 R10: address bytes
                ACT_ADDR: begin
                    if (bs) begin
                        st_nxt.addr_hi = dbus;
                    end else begin
                        st_nxt.addr_lo = dbus;
                    end
                end
                // R05 R06: data bytes
                ACT_DATA: begin
                    if (bs) begin
                        st_nxt.data_hi = dbus;
                    end else begin
                        st_nxt.data_lo = dbus;
                    end
                end
                // R14: command load, nop clears write
                ACT_CMD: begin
                    st_nxt.cmd = dbus;
                end
                default: begin
                end
            endcase
        end
        // R07: page latch with byte select high
        if (latch_rise && bs && st_r.st == ST_IDLE) begin
            st_nxt.arm = 1'b1;
        end
        unique case (st_r.st)
            ST_IDLE: begin
                // R03 R11: write strobe runs page write command
                if (wr_fall && st_r.cmd == CMD_WRITE_FLASH) begin
                    st_nxt.st   = ST_PROG;
                    st_nxt.rdy  = 1'b0;
                    st_nxt.word = '0;
                    st_nxt.cnt  = CNT_RST;
                    // R09: page from high byte and top of low byte
                    st_nxt.page = PAGE_BITS'({st_r.addr_hi, st_r.addr_lo} >> WORD_BITS);
                end
            end
            ST_PROG: begin
                // Stream buffer out, then hold busy for the write time
                st_nxt.cnt = st_r.cnt + 16'h0001;
                if (st_r.cnt >= 16'(1) && st_r.cnt <= 16'(PAGE_WORDS)) begin
                    st_nxt.we    = 1'b1;
                    st_nxt.wdata = buf_rd;
                    st_nxt.fword = WORD_BITS'(st_r.cnt - 16'h0001); // Index of word now leaving
                end
                if (st_r.cnt < 16'(PAGE_WORDS)) begin
                    st_nxt.word = st_r.word + 1'b1;
                end
                if (st_r.cnt >= 16'(PROG_CYC)) begin
                    st_nxt.st = ST_DONE;
                end
            end
            ST_DONE: begin
                // R15: ready again after write
                st_nxt.st  = ST_IDLE;
                st_nxt.rdy = 1'b1;
            end
            default: begin
                st_nxt.st  = ST_IDLE;
                st_nxt.rdy = 1'b1;
            end
        endcase
        // Output enable is accepted; reads are not part of this block
        if (oe_fall) begin
            st_nxt.cmd = st_nxt.cmd;
        end
    end

    // State register
    always_ff @(posedge mclk_i or negedge rst_s_r) begin
        if (!rst_s_r) begin
            st_r <= '{st: ST_IDLE, addr_lo: BYTE_RST, addr_hi: BYTE_RST, data_lo: BYTE_RST,
                      data_hi: BYTE_RST, cmd: CMD_NOP, cnt: CNT_RST, word: '0, page: '0,
                      rdy: 1'b1, we: 1'b0, wdata: WORD_RST, arm: 1'b0, fword: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Registered outputs
    assign ready_busy_out_o = st_r.rdy;
    assign flash_we_o       = st_r.we;
    assign flash_page_o     = st_r.page;
    assign flash_word_o     = st_r.fword;
    assign flash_data_o     = st_r.wdata;
    assign command_o        = st_r.cmd;

    // R11: busy follows a write strobe with write command
    a_busy_after_wr: assert property (@(posedge mclk_i) disable iff (!rst_s_r) // R11
        (st_r.st == ST_IDLE && wr_fall && st_r.cmd == CMD_WRITE_FLASH) |=> !ready_busy_out_o)
        else $error("ready_busy did not drop after write strobe");

    // R15: ready whenever idle
    a_ready_idle: assert property (@(posedge mclk_i) disable iff (!rst_s_r) // R15
        (st_r.st == ST_IDLE) |-> ready_busy_out_o)
        else $error("ready_busy low while idle");

    // R04: address low captured
    a_addr_lo_load: assert property (@(posedge mclk_i) disable iff (!rst_s_r) // R04
        (st_r.st == ST_IDLE && load_rise && act_s_r == ACT_ADDR && !bs) |=> st_r.addr_lo == $past(dbus))
        else $error("address low byte not captured");

    // R10: address high captured
    a_addr_hi_load: assert property (@(posedge mclk_i) disable iff (!rst_s_r) // R10
        (st_r.st == ST_IDLE && load_rise && act_s_r == ACT_ADDR && bs) |=> st_r.addr_hi == $past(dbus))
        else $error("address high byte not captured");

    // R05 R06: data bytes captured
    a_data_load: assert property (@(posedge mclk_i) disable iff (!rst_s_r) // R05 R06
        (st_r.st == ST_IDLE && load_rise && act_s_r == ACT_DATA) |=>
        ($past(bs) ? st_r.data_hi : st_r.data_lo) == $past(dbus))
        else $error("data byte not captured");

    // R07: latch arms the buffer write
    a_latch_word: assert property (@(posedge mclk_i) disable iff (!rst_s_r) // R07
        (st_r.st == ST_IDLE && latch_rise && bs) |=> st_r.arm)
        else $error("page latch ignored");

    // R14: command load stores bus value
    a_cmd_load: assert property (@(posedge mclk_i) disable iff (!rst_s_r) // R14
        (st_r.st == ST_IDLE && load_rise && act_s_r == ACT_CMD) |=> command_o == $past(dbus))
        else $error("command not loaded");

    // R03: other commands leave the device ready
    a_no_cmd_idle: assert property (@(posedge mclk_i) disable iff (!rst_s_r) // R03
        (st_r.st == ST_IDLE && wr_fall && st_r.cmd != CMD_WRITE_FLASH) |=> ready_busy_out_o)
        else $error("write strobe acted without write command");

    // R09: page number taken from address
    a_page_sel: assert property (@(posedge mclk_i) disable iff (!rst_s_r) // R09
        (st_r.st == ST_IDLE && wr_fall && st_r.cmd == CMD_WRITE_FLASH) |=>
        flash_page_o == PAGE_BITS'({$past(st_r.addr_hi), $past(st_r.addr_lo)} >> WORD_BITS))
        else $error("page number wrong");

endmodule : ppp_programmer

// [testbench/ppp_prog_model.sv]
// Programmer model: drives the pins of the parallel programming port.
// Assumes the device samples every pin on mclk_i; pins change after an edge.
`timescale 1ns/100ps
module ppp_prog_model
    import ppp_pkg::*;
(
    // Clock
    input  wire logic       mclk_i,
    // Programming pins
    output logic            load_strobe_pin_o,
    output logic            action_select_hi_o,
    output logic            action_select_lo_o,
    output logic            byte_select_o,
    output logic            page_latch_strobe_o,
    output logic            wr_b_o,
    output logic            oe_b_o,
    output logic [7:0]      data_o
);
    localparam int PW = MIN_PULSE_CYC + 1;

    // Idle pin levels
    initial begin
        load_strobe_pin_o   = 1'b0;
        action_select_hi_o  = 1'b0;
        action_select_lo_o  = 1'b0;
        byte_select_o       = 1'b0;
        page_latch_strobe_o = 1'b0;
        wr_b_o              = 1'b1;
        oe_b_o              = 1'b1;
        data_o              = 8'h00;
    end

    // Wait a number of clock edges
    task automatic hold(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : hold

    task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] d);
        @(posedge mclk_i);
        {action_select_hi_o, action_select_lo_o} <= act;
        byte_select_o <= bs;
        data_o        <= d;
        hold(2);
        load_strobe_pin_o <= 1'b1;
        hold(PW);
        load_strobe_pin_o <= 1'b0;
        hold(3);
        // Released bus shows the inverse, never a stale value
        data_o <= ~d;
    endtask : load

    task automatic latch();
        @(posedge mclk_i);
        byte_select_o <= 1'b1;
        hold(2);
        page_latch_strobe_o <= 1'b1;
        hold(PW);
        page_latch_strobe_o <= 1'b0;
        hold(3);
    endtask : latch

    task automatic write_pulse();
        @(posedge mclk_i);
        wr_b_o <= 1'b0;
        hold(PW);
        wr_b_o <= 1'b1;
    endtask : write_pulse
endmodule : ppp_prog_model

// [testbench/tb_top.sv]
// Testbench: loads and writes two pages, then checks the no-operation command.
// Assumes a 100 MHz clock and a shortened page write time.
`timescale 1ns/100ps
module tb_top;
    import ppp_pkg::*;
    localparam int PROG = 100;

    // Clock, reset and pins
    logic                 mclk_i  = 1'b0;
    logic                 rst_b_i = 1'b0;
    logic                 lstr, ash, asl, bsel, plat, wrb, oeb;
    logic [7:0]           data;
    logic                 ready_busy_out_o, flash_we_o;
    logic [PAGE_BITS-1:0] flash_page_o;
    logic [WORD_BITS-1:0] flash_word_o;
    logic [15:0]          flash_data_o;
    logic [7:0]           command_o;
    int                   fails = 0;
    int                   n_compared = 0;
    int                   n_we = 0;
    logic [15:0]          got_w [64];
    logic [6:0]           got_page;

    // Clock generator
    always #5 mclk_i = ~mclk_i;

    ppp_prog_model pm_u (.mclk_i(mclk_i), .load_strobe_pin_o(lstr), .action_select_hi_o(ash),
        .action_select_lo_o(asl), .byte_select_o(bsel), .page_latch_strobe_o(plat), .wr_b_o(wrb),
        .oe_b_o(oeb), .data_o(data));

    ppp_programmer #(.PROG_CYC(PROG)) dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .load_strobe_pin_i(lstr),
        .action_select_hi_i(ash), .action_select_lo_i(asl), .byte_select_i(bsel),
        .page_latch_strobe_i(plat), .wr_b_i(wrb), .oe_b_i(oeb), .data_i(data),
        .ready_busy_out_o(ready_busy_out_o), .flash_we_o(flash_we_o), .flash_page_o(flash_page_o),
        .flash_word_o(flash_word_o), .flash_data_o(flash_data_o), .command_o(command_o));

    // Record every word written to the array
    always @(posedge mclk_i) begin
        if (flash_we_o === 1'b1) begin
            got_w[flash_word_o] <= flash_data_o;
            got_page            <= flash_page_o;
            n_we                <= n_we + 1;
        end
    end

    // Verdict and end of run
    task automatic finish_test();
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    // Value comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // Bounded wait for a ready level
    task automatic wait_ready(input logic lvl, input int lim);
        for (int i = 0; i < lim && ready_busy_out_o !== lvl; i++) @(negedge mclk_i);
        chk(16'(ready_busy_out_o), 16'(lvl), "ready level");
    endtask : wait_ready

    // Idle state after reset
    task automatic t_reset();
        chk(16'(ready_busy_out_o), 16'h0001, "ready after reset");
        chk(16'(flash_we_o), 16'h0000, "write pulse after reset");
        chk(16'(command_o), 16'(CMD_NOP), "command after reset");
    endtask : t_reset

    // Load a full page, program it and check every word
    task automatic t_page(input logic [7:0] ahi, input logic [1:0] top, input logic [7:0] base);
        int n0;
        for (int w = 0; w < PAGE_WORDS; w++) begin
            pm_u.load(ACT_ADDR, 1'b0, {top, 6'(w)});
            pm_u.load(ACT_DATA, 1'b0, 8'(w) ^ base);
            pm_u.load(ACT_DATA, 1'b1, 8'(w) + base);
            pm_u.latch();
        end
        pm_u.load(ACT_ADDR, 1'b1, ahi);
        pm_u.load(ACT_CMD, 1'b0, CMD_WRITE_FLASH);
        pm_u.hold(8);
        chk(16'(command_o), 16'(CMD_WRITE_FLASH), "command load");
        chk(16'(ready_busy_out_o), 16'h0001, "ready before write");
        n0 = n_we;
        pm_u.write_pulse();
        wait_ready(1'b0, 20);
        pm_u.load(ACT_CMD, 1'b0, CMD_NOP);
        wait_ready(1'b1, PROG + 40);
        chk(16'(command_o), 16'(CMD_WRITE_FLASH), "load refused while busy");
        pm_u.hold(2);
        chk(16'(n_we - n0), 16'(PAGE_WORDS), "words written");
        chk(16'(got_page), 16'(7'({ahi, top, 6'h00} >> 6)), "page number");
        for (int w = 0; w < PAGE_WORDS; w++)
            chk(got_w[w], {8'(w) + base, 8'(w) ^ base}, "word data");
    endtask : t_page

    // No-operation disarms the write strobe
    task automatic t_nop();
        int n0;
        pm_u.load(ACT_CMD, 1'b0, CMD_NOP);
        pm_u.hold(8);
        chk(16'(command_o), 16'(CMD_NOP), "nop load");
        n0 = n_we;
        pm_u.write_pulse();
        chk(16'(ready_busy_out_o), 16'h0001, "ready after disarmed write");
        pm_u.hold(PROG);
        chk(16'(n_we - n0), 16'h0000, "words after disarmed write");
    endtask : t_nop

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        t_reset();
        t_page(8'h05, 2'b10, 8'h3c);
        t_page(8'h00, 2'b01, 8'hc3);
        t_nop();
        finish_test();
    end

    // Watchdog
    initial begin
        repeat (60000) @(posedge mclk_i);
        fails++;
        finish_test();
    end
endmodule : tb_top
